// file: verilog/ep_handshake_ctrl.sv
// Design decision made here: register access over APB.
`timescale 1ns/100ps
// Functional notes
// - No per-endpoint FIFO; payloads up to 1280 bytes
// - Sixteen 8-bit control registers, reset to zero
// - Isochronous IN data send always succeeds, packet completes
// - Non-isochronous IN waits for host ACK
// - Successful packet dequeued and released automatically
// - Isochronous OUT/SETUP gets no handshake
// - Address match starts a new buffered packet
// - IN code: off, or always STALL
// - IN code: normal data/NAK, or forced NAK
// - OUT code: off, or always STALL
// - OUT code: ACK/NAK by space, or NAK
// - Transmit toggle flips after each successful send
// - Bit 0 shows last received data toggle
// - Token endpoint number selects the register
module ep_handshake_ctrl #(
	parameter int unsigned NUM_EP = ep_hs_pkg::NUM_EP,
	parameter int unsigned MAX_PAYLOAD = ep_hs_pkg::MAX_PAYLOAD
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire ep_hs_pkg::token_s token,
	input wire logic addr_match,
	input wire logic [10:0] payload_len,
	input wire logic [NUM_EP-1:0] queue_has_data,
	input wire logic rx_space_ok,
	input wire logic host_ack,
	input wire logic host_timeout,
	input wire logic rx_done,
	input wire logic rx_data_toggle,
	output ep_hs_pkg::reply_s reply,
	output logic tx_complete,
	output logic [3:0] tx_complete_ep,
	output logic packet_start,
	output logic [10:0] packet_len,
	output logic oversize
);
	// Indices and lengths are fixed-width ports, so only these fit
	if (NUM_EP != ep_hs_pkg::NUM_EP || MAX_PAYLOAD > 11'h7FF)
	begin : g_param_check
		$error("ep_handshake_ctrl: unsupported parameters");
	end

	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b001,
		ST_WAIT_ACK = 3'b010,
		ST_WAIT_RX = 3'b100
	} state_e;

	typedef struct packed
	{
		logic [NUM_EP-1:0][7:0] ctrl;
		state_e st;
		logic [3:0] cur_ep;
		logic [31:0] prdata;
		logic pslverr;
		logic pready;
		ep_hs_pkg::reply_s reply;
		logic tx_complete;
		logic [3:0] tx_complete_ep;
		logic packet_start;
		logic [10:0] packet_len;
		logic oversize;
	} state_s;

	state_s s_q;
	state_s s_d;

	logic wr_go;
	logic rd_go;
	logic hit;
	logic [3:0] reg_idx;
	ep_hs_pkg::reply_e answer;
	logic iso;
	logic is_in;
	logic tok_busy;

	apb_byte_slave u_apb
	(
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.wr_go(wr_go),
		.rd_go(rd_go),
		.hit(hit),
		.index(reg_idx)
	);

	assign is_in = (token.kind == ep_hs_pkg::TOK_IN);

	// Register chosen by the token endpoint number
	endpoint_control_field u_field
	(
		.ctrl(s_q.ctrl[token.ep]),
		.is_in(is_in),
		.queue_has_data(queue_has_data[token.ep]),
		.rx_space_ok(rx_space_ok),
		.answer(answer),
		.iso(iso)
	);

	// Tokens arriving mid-transaction are dropped
	assign tok_busy = (s_q.st != ST_IDLE);

	always_comb
	begin
		s_d = s_q;
		s_d.reply.valid = 1'b0;
		s_d.tx_complete = 1'b0;
		s_d.packet_start = 1'b0;
		s_d.oversize = 1'b0;
		s_d.pslverr = 1'b0;

		// Writes change only the stored byte; an open transaction
		// already latched its answer, so it is not disturbed.
		if (wr_go)
		begin
			s_d.ctrl[reg_idx] = (pwdata[7:0] & ep_hs_pkg::WRITABLE_MASK)
				| (s_q.ctrl[reg_idx] & ~ep_hs_pkg::WRITABLE_MASK);
		end
		if (rd_go)
			s_d.prdata = hit ? {24'h000000, s_q.ctrl[reg_idx]} : 32'h00000000;
		if (psel && !penable)
			s_d.pslverr = !hit;

		case (s_q.st)
			ST_IDLE:
			begin
				if (token.valid)
				begin
					s_d.cur_ep = token.ep;
					s_d.reply.valid = (answer != ep_hs_pkg::REPLY_NONE);
					s_d.reply.kind = answer;
					s_d.reply.data_toggle =
						s_q.ctrl[token.ep][ep_hs_pkg::BIT_IN_TOG];
					if (is_in && answer == ep_hs_pkg::REPLY_DATA)
					begin
						if (iso)
						begin
							// No ACK expected: done at once
							s_d.tx_complete = 1'b1;
							s_d.tx_complete_ep = token.ep;
							s_d.ctrl[token.ep][ep_hs_pkg::BIT_IN_TOG] =
								~s_q.ctrl[token.ep][ep_hs_pkg::BIT_IN_TOG];
						end
						else
							s_d.st = ST_WAIT_ACK;
					end
					else if (!is_in && addr_match)
					begin
						s_d.packet_start = 1'b1;
						s_d.packet_len = payload_len;
						s_d.oversize = (payload_len >
							11'(MAX_PAYLOAD));
						s_d.st = ST_WAIT_RX;
					end
				end
			end
			ST_WAIT_ACK:
			begin
				if (host_ack)
				begin
					s_d.tx_complete = 1'b1;
					s_d.tx_complete_ep = s_q.cur_ep;
					s_d.ctrl[s_q.cur_ep][ep_hs_pkg::BIT_IN_TOG] =
						~s_q.ctrl[s_q.cur_ep][ep_hs_pkg::BIT_IN_TOG];
					s_d.st = ST_IDLE;
				end
				else if (host_timeout)
					s_d.st = ST_IDLE;
			end
			ST_WAIT_RX:
			begin
				if (rx_done)
				begin
					s_d.ctrl[s_q.cur_ep][ep_hs_pkg::BIT_OUT_TOG] =
						rx_data_toggle;
					s_d.st = ST_IDLE;
				end
				else if (host_timeout)
					s_d.st = ST_IDLE;
			end
			default:
				s_d.st = ST_IDLE;
		endcase
		if (tok_busy && token.valid)
			s_d.reply.valid = 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_q.ctrl <= {NUM_EP{ep_hs_pkg::ENDPOINT_CONTROL_RESET}};
			s_q.st <= ST_IDLE;
			s_q.cur_ep <= 4'h0;
			s_q.prdata <= 32'h00000000;
			s_q.pslverr <= 1'b0;
			// Zero-wait slave: ready is held high from reset on
			s_q.pready <= 1'b1;
			s_q.reply <= '0;
			s_q.tx_complete <= 1'b0;
			s_q.tx_complete_ep <= 4'h0;
			s_q.packet_start <= 1'b0;
			s_q.packet_len <= 11'h000;
			s_q.oversize <= 1'b0;
		end
		else
			s_q <= s_d;
	end

	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign reply = s_q.reply;
	assign tx_complete = s_q.tx_complete;
	assign tx_complete_ep = s_q.tx_complete_ep;
	assign packet_start = s_q.packet_start;
	assign packet_len = s_q.packet_len;
	assign oversize = s_q.oversize;
endmodule : ep_handshake_ctrl

// file: verilog/ep_hs_pkg.sv
package ep_hs_pkg;
	localparam int unsigned NUM_EP = 16;
	localparam logic [15:0] ENDPOINT_CONTROL_BASE = 16'h7F80;
	localparam logic [15:0] ENDPOINT_CONTROL_LAST = 16'h7F8F;
	localparam logic [7:0] ENDPOINT_CONTROL_RESET = 8'h00;
	localparam int unsigned MAX_PAYLOAD = 1280;
	localparam int unsigned BIT_IN_ISO = 7;
	localparam int unsigned BIT_OUT_ISO = 6;
	localparam int unsigned BIT_IN_HS1 = 5;
	localparam int unsigned BIT_OUT_HS1 = 4;
	localparam int unsigned BIT_IN_HS0 = 3;
	localparam int unsigned BIT_OUT_HS0 = 2;
	localparam int unsigned BIT_IN_TOG = 1;
	localparam int unsigned BIT_OUT_TOG = 0;
	localparam logic [7:0] WRITABLE_MASK = 8'hFE;
	localparam logic [1:0] HS_OFF = 2'h0;
	localparam logic [1:0] HS_STALL = 2'h1;
	localparam logic [1:0] HS_NORMAL = 2'h2;
	localparam logic [1:0] HS_FORCE_NAK = 2'h3;

	typedef enum logic [1:0]
	{
		TOK_IN = 2'h0,
		TOK_OUT = 2'h1,
		TOK_SETUP = 2'h2
	} token_e;

	typedef enum logic [2:0]
	{
		REPLY_NONE = 3'h0,
		REPLY_ACK = 3'h1,
		REPLY_NAK = 3'h2,
		REPLY_STALL = 3'h3,
		REPLY_DATA = 3'h4
	} reply_e;

	typedef struct packed
	{
		logic valid;
		token_e kind;
		logic [3:0] ep;
	} token_s;

	typedef struct packed
	{
		logic valid;
		reply_e kind;
		logic data_toggle;
	} reply_s;
endpackage : ep_hs_pkg

// file: verilog/endpoint_control_field.sv
`timescale 1ns/100ps
// Decodes one endpoint control byte into the handshake answer
module endpoint_control_field
(
	input wire logic [7:0] ctrl,
	input wire logic is_in,
	input wire logic queue_has_data,
	input wire logic rx_space_ok,
	output ep_hs_pkg::reply_e answer,
	output logic iso
);
	logic [1:0] code;
	always_comb
	begin
		if (is_in)
		begin
			code = {ctrl[ep_hs_pkg::BIT_IN_HS1], ctrl[ep_hs_pkg::BIT_IN_HS0]};
			iso = ctrl[ep_hs_pkg::BIT_IN_ISO];
		end
		else
		begin
			code = {ctrl[ep_hs_pkg::BIT_OUT_HS1],
				ctrl[ep_hs_pkg::BIT_OUT_HS0]};
			iso = ctrl[ep_hs_pkg::BIT_OUT_ISO];
		end
		case (code)
			ep_hs_pkg::HS_STALL:
				answer = ep_hs_pkg::REPLY_STALL;
			ep_hs_pkg::HS_NORMAL:
				if (is_in)
					answer = queue_has_data ? ep_hs_pkg::REPLY_DATA
						: ep_hs_pkg::REPLY_NAK;
				else
					answer = rx_space_ok ? ep_hs_pkg::REPLY_ACK
						: ep_hs_pkg::REPLY_NAK;
			ep_hs_pkg::HS_FORCE_NAK:
				answer = ep_hs_pkg::REPLY_NAK;
			default:
				answer = ep_hs_pkg::REPLY_NONE;
		endcase
		// Isochronous receive never answers, even when stalled
		if (!is_in && iso)
			answer = ep_hs_pkg::REPLY_NONE;
	end
endmodule : endpoint_control_field

// file: verilog/apb_byte_slave.sv
`timescale 1ns/100ps
// Zero-wait APB slave front end; answers in the first access cycle
module apb_byte_slave
(
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	output logic wr_go,
	output logic rd_go,
	output logic hit,
	output logic [3:0] index
);
	always_comb
	begin
		hit = (paddr >= ep_hs_pkg::ENDPOINT_CONTROL_BASE)
			&& (paddr <= ep_hs_pkg::ENDPOINT_CONTROL_LAST);
		index = paddr[3:0];
		wr_go = psel && penable && pwrite && hit;
		rd_go = psel && !penable && !pwrite;
	end
endmodule : apb_byte_slave

// file: bench/ep_hs_checker.sv
`timescale 1ns/100ps
module ep_hs_checker
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire ep_hs_pkg::token_s token,
	input wire logic addr_match,
	input wire logic [10:0] payload_len,
	input wire logic host_ack,
	input wire ep_hs_pkg::reply_s reply,
	input wire logic tx_complete,
	input wire logic packet_start,
	input wire logic [10:0] packet_len,
	input wire logic oversize
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic off_map;
	assign off_map = paddr > ep_hs_pkg::ENDPOINT_CONTROL_LAST
		|| paddr < ep_hs_pkg::ENDPOINT_CONTROL_BASE;
	sequence rx_tok_s;
		token.valid && token.kind != ep_hs_pkg::TOK_IN;
	endsequence
	zero_wait_a: assert property (psel |-> pready)
		else $error("wait state");
	map_err_a: assert property (psel && penable |-> pslverr == off_map)
		else $error("slave error");
	off_read_a: assert property (psel && penable && !pwrite
		&& off_map |-> prdata == 32'h0) else $error("off read");
	size_flag_a: assert property (packet_start
		|-> oversize == (packet_len > 11'(ep_hs_pkg::MAX_PAYLOAD)))
		else $error("oversize flag");
	reply_cause_a: assert property (reply.valid |-> $past(token.valid))
		else $error("stray reply");
	data_in_a: assert property (reply.valid
		&& reply.kind == ep_hs_pkg::REPLY_DATA
		|-> $past(token.kind) == ep_hs_pkg::TOK_IN) else $error("data");
	ack_out_a: assert property (reply.valid
		&& reply.kind == ep_hs_pkg::REPLY_ACK
		|-> $past(token.kind) != ep_hs_pkg::TOK_IN) else $error("ack");
	start_len_a: assert property (rx_tok_s ##1 packet_start
		|-> packet_len == $past(payload_len)) else $error("length");
	start_cause_a: assert property (packet_start
		|-> $past(token.valid && addr_match)) else $error("start");
	tx_done_a: assert property (tx_complete |-> $past(host_ack)
		|| reply.valid) else $error("completion");
endmodule : ep_hs_checker

bind ep_handshake_ctrl ep_hs_checker u_chk (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .token,
	.addr_match, .payload_len, .host_ack, .reply, .tx_complete,
	.packet_start, .packet_len, .oversize);

// file: bench/usb_host_model.sv
`timescale 1ns/100ps
module usb_host_model
(
	input wire logic pclk,
	input wire ep_hs_pkg::reply_s reply,
	output ep_hs_pkg::token_s token = '0,
	output logic addr_match = 0,
	output logic host_ack = 0,
	output logic rx_done = 0,
	output logic rx_data_toggle = 0
);
	task automatic tok(input ep_hs_pkg::token_e k, input logic [3:0] e,
		input logic m, output ep_hs_pkg::reply_s r);
		@(posedge pclk);
		token <= '{1'b1, k, e};
		addr_match <= m;
		@(posedge pclk);
		// Released endpoint and match scrambled so nothing leans on stale values
		token <= '{1'b0, k, ~e};
		addr_match <= ~m;
		@(posedge pclk);
		r = reply;
	endtask : tok
	task automatic ack();
		@(posedge pclk);
		host_ack <= 1'b1;
		@(posedge pclk);
		host_ack <= 1'b0;
		@(posedge pclk);
	endtask : ack
	task automatic done(input logic t);
		@(posedge pclk);
		rx_done <= 1'b1;
		rx_data_toggle <= t;
		@(posedge pclk);
		rx_done <= 1'b0;
		rx_data_toggle <= ~t;
	endtask : done
endmodule : usb_host_model

// file: bench/usb_endpoint_handshake_control_bench.sv
`timescale 1ns/100ps
`define CHK(g, x) begin cmp_count++; if ((g) !== (x)) begin n_fail++; \
$display("mismatch at %0t: got %h exp %h", $time, g, x); end end
module usb_endpoint_handshake_control_bench;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [15:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, d;
	logic pready, pslverr, addr_match, host_ack, rx_done, rx_data_toggle, e;
	logic [15:0] queue_has_data = '0;
	logic rx_space_ok = 1;
	logic [10:0] payload_len = 11'h500;
	logic tx_complete, packet_start, oversize;
	logic [3:0] tx_complete_ep;
	logic [10:0] packet_len;
	ep_hs_pkg::token_s token;
	ep_hs_pkg::reply_s reply, r;
	// Valid bit over reply code, per handshake code 0..3
	logic [3:0] in_x [4] = '{4'h0, 4'hB, 4'hC, 4'hA};
	logic [3:0] out_x [4] = '{4'h0, 4'hB, 4'h9, 4'hA};
	int n_fail = 0;
	int cmp_count = 0;
	always #25 pclk = ~pclk;
	ep_handshake_ctrl u_dut (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .token, .addr_match,
		.payload_len, .queue_has_data, .rx_space_ok, .host_ack,
		.host_timeout(1'b0), .rx_done, .rx_data_toggle, .reply,
		.tx_complete, .tx_complete_ep, .packet_start, .packet_len,
		.oversize);
	usb_host_model host (.pclk, .reply, .token, .addr_match, .host_ack,
		.rx_done, .rx_data_toggle);
	task automatic apb(input logic w, input logic [15:0] a,
		input logic [7:0] v);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, v};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		d = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [15:0] a, input logic [31:0] x);
		apb(1'b0, a, 8'h00);
		`CHK(d, x)
	endtask : rd
	task automatic tk(input ep_hs_pkg::token_e k, input logic [3:0] n,
		input logic m, input logic [3:0] x);
		host.tok(k, n, m, r);
		`CHK(({r.valid, r.kind}), x)
	endtask : tk
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : give_verdict
	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rd(16'h7F80, 32'h0);
		rd(16'h7F8F, 32'h0);
		`CHK(e, 1'b0)
		apb(1'b1, 16'h7F90, 8'h5A);
		rd(16'h7F90, 32'h0);
		`CHK(e, 1'b1)
		apb(1'b1, 16'h7F85, 8'hFF);
		rd(16'h7F85, 32'hFE);
		queue_has_data[2] <= 1'b1;
		for (int c = 0; c < 4; c++)
		begin
			apb(1'b1, 16'h7F82, {2'b00, c[1], 1'b0, c[0], 3'b000});
			tk(ep_hs_pkg::TOK_IN, 4'h2, 1'b0, in_x[c]);
			if (c == 2)
			begin
				`CHK(r.data_toggle, 1'b0)
				host.ack();
				`CHK(tx_complete, 1'b1)
				`CHK(tx_complete_ep, 4'h2)
				rd(16'h7F82, 32'h22);
				// Take the endpoint off-line before touching its toggle
				apb(1'b1, 16'h7F82, 8'h02);
				apb(1'b1, 16'h7F82, 8'h00);
			end
		end
		queue_has_data[2] <= 1'b0;
		apb(1'b1, 16'h7F82, 8'h20);
		tk(ep_hs_pkg::TOK_IN, 4'h2, 1'b0, 4'hA);
		queue_has_data[4] <= 1'b1;
		apb(1'b1, 16'h7F84, 8'hA0);
		tk(ep_hs_pkg::TOK_IN, 4'h4, 1'b0, 4'hC);
		`CHK(tx_complete, 1'b1)
		rd(16'h7F84, 32'hA2);
		tk(ep_hs_pkg::TOK_IN, 4'h4, 1'b0, 4'hC);
		`CHK(r.data_toggle, 1'b1)
		for (int c = 0; c < 4; c++)
		begin
			apb(1'b1, 16'h7F86, {3'b000, c[1], 1'b0, c[0], 2'b00});
			tk(ep_hs_pkg::TOK_OUT, 4'h6, 1'b0, out_x[c]);
		end
		rx_space_ok <= 1'b0;
		apb(1'b1, 16'h7F86, 8'h10);
		tk(ep_hs_pkg::TOK_OUT, 4'h6, 1'b0, 4'hA);
		apb(1'b1, 16'h7F87, 8'h50);
		tk(ep_hs_pkg::TOK_SETUP, 4'h7, 1'b1, 4'h0);
		`CHK(packet_start, 1'b1)
		`CHK(packet_len, 11'h500)
		`CHK(oversize, 1'b0)
		host.done(1'b1);
		rd(16'h7F87, 32'h51);
		payload_len <= 11'h501;
		tk(ep_hs_pkg::TOK_OUT, 4'h7, 1'b1, 4'h0);
		`CHK(oversize, 1'b1)
		host.done(1'b0);
		rd(16'h7F87, 32'h50);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(16'h7F87, 32'h0);
		give_verdict();
	end
	initial
	begin
		#20us;
		n_fail++;
		give_verdict();
	end
endmodule : usb_endpoint_handshake_control_bench
